/* File: shared/sramc_pkg.sv */
// package: timing and geometry constants for the async sram host controller
package sramc_pkg;
  localparam int unsigned CLK_PERIOD_NS      = 50;
  localparam int unsigned ADDR_W             = 13;
  localparam int unsigned DATA_W             = 8;
  // slowest grade figures, ns
  localparam int unsigned WRITE_PULSE_MIN_NS = 90;
  localparam int unsigned SELECT_TO_END_NS   = 100;
  localparam int unsigned ADDR_TO_END_NS     = 100;
  localparam int unsigned DATA_OVERLAP_NS    = 60;
  localparam int unsigned WRITE_RECOVERY_NS  = 15;
  localparam int unsigned ACCESS_TIME_NS     = 150;
  localparam int unsigned GATE_VALID_NS      = 70;
  localparam int unsigned FLOAT_DELAY_NS     = 50;
  // least times round up to whole cycles
  localparam int unsigned WP_CYC  = (WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CW_CYC  = (SELECT_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned AW_CYC  = (ADDR_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DW_CYC  = (DATA_OVERLAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_CYC  = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned AA_CYC  = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OE_CYC  = (GATE_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HZ_CYC  = (FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // write strobe low time: longer of the pulse and select windows
  localparam int unsigned WRITE_CYC = (CW_CYC > WP_CYC) ? CW_CYC : WP_CYC;
  // read sample point: later of access and gate paths plus one sampling cycle
  localparam int unsigned READ_CYC  = ((AA_CYC > OE_CYC) ? AA_CYC : OE_CYC) + 1;
  localparam int unsigned CNT_W     = 4;
  typedef enum logic [2:0] {
    SRAMC_IDLE,
    SRAMC_WSETUP,
    SRAMC_WPULSE,
    SRAMC_WHOLD,
    SRAMC_READ,
    SRAMC_RDONE
  } sramc_state_t;
endpackage : sramc_pkg

/* File: verilog/sramc_ctrl.sv */
// host controller that runs read and write cycles on an async 8k x 8 sram
`timescale 1ns/1ps
// What this block does
// - write only while both selects and strobe active
// - strobe low at least write pulse minimum
// - selects held active before write end
// - address valid before write begins
// - address held after write ends
// - address stable before write end
// - data driven before write end
// - data may drop at write end
// - never fight device-driven data pins
// - strobe high throughout every read
module sramc_ctrl #(
  parameter int unsigned ADDR_W = sramc_pkg::ADDR_W,
  parameter int unsigned DATA_W = sramc_pkg::DATA_W
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   select_active_low_b,
  output logic                   select_active_high,
  output logic                   write_strobe_b,
  output logic                   output_gate_b,
  input  wire logic [DATA_W-1:0] mem_data_in,
  output logic [DATA_W-1:0]      mem_data_out,
  output logic                   mem_data_oe
);
  localparam logic [sramc_pkg::CNT_W-1:0] WRITE_LEN =
    sramc_pkg::CNT_W'(sramc_pkg::WRITE_CYC);
  localparam logic [sramc_pkg::CNT_W-1:0] READ_LEN =
    sramc_pkg::CNT_W'(sramc_pkg::READ_CYC);
  localparam logic [sramc_pkg::CNT_W-1:0] FLOAT_LEN =
    sramc_pkg::CNT_W'(sramc_pkg::HZ_CYC);
  localparam logic [sramc_pkg::CNT_W-1:0] HOLD_LEN =
    sramc_pkg::CNT_W'(sramc_pkg::WR_CYC);

  // refuse geometry the counters or widths cannot serve
  initial
  begin
    if (ADDR_W < 1 || DATA_W < 1 || sramc_pkg::READ_CYC >= (1 << sramc_pkg::CNT_W))
      $error("sramc_ctrl: unsupported parameters");
  end

  sramc_pkg::sramc_state_t state_reg;
  sramc_pkg::sramc_state_t state_next;
  logic [sramc_pkg::CNT_W-1:0] cnt_reg;
  logic [sramc_pkg::CNT_W-1:0] cnt_next;
  logic                        cnt_done;
  logic                        take_req;

  // request and counter decode
  assign cnt_done = (cnt_reg == '0);
  assign take_req = req_valid && req_ready && (state_reg == sramc_pkg::SRAMC_IDLE);

  // sequencing; the write pulse stays in WPULSE until counted out
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_done ? cnt_reg : cnt_reg - 1'b1;
    case (state_reg)
      sramc_pkg::SRAMC_IDLE:
        if (take_req)
        begin
          // write waits out any device drive before owning the pins
          state_next = req_write ? sramc_pkg::SRAMC_WSETUP : sramc_pkg::SRAMC_READ;
          cnt_next   = req_write ? FLOAT_LEN : READ_LEN;
        end
      sramc_pkg::SRAMC_WSETUP:
        if (cnt_done)
        begin
          state_next = sramc_pkg::SRAMC_WPULSE;
          cnt_next   = WRITE_LEN - 1'b1;
        end
      sramc_pkg::SRAMC_WPULSE:
        if (cnt_done)
        begin
          state_next = sramc_pkg::SRAMC_WHOLD;
          cnt_next   = HOLD_LEN - 1'b1;
        end
      sramc_pkg::SRAMC_WHOLD:
        if (cnt_done)
          state_next = sramc_pkg::SRAMC_IDLE;
      sramc_pkg::SRAMC_READ:
        if (cnt_done)
          state_next = sramc_pkg::SRAMC_RDONE;
      sramc_pkg::SRAMC_RDONE:
        state_next = sramc_pkg::SRAMC_IDLE;
      default:
        state_next = sramc_pkg::SRAMC_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_reg <= sramc_pkg::SRAMC_IDLE;
      cnt_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // strobe phase decode; shared by the strobe and data-drive flops
  function automatic logic is_pulse_state(input sramc_pkg::sramc_state_t s);
    return (s == sramc_pkg::SRAMC_WPULSE);
  endfunction : is_pulse_state

  // pin drive: selects rise with the request, strobe only in WPULSE
  wire logic pulse_next = is_pulse_state(state_next);
  wire logic in_write = (state_next == sramc_pkg::SRAMC_WSETUP) ||
                        (state_next == sramc_pkg::SRAMC_WPULSE) ||
                        (state_next == sramc_pkg::SRAMC_WHOLD);
  wire logic in_read  = (state_next == sramc_pkg::SRAMC_READ);
  wire logic busy     = in_write || in_read;

  // address and data latched once per request so they stay stable
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      mem_addr            <= '0;
      mem_data_out        <= '0;
      select_active_low_b <= 1'b1;
      select_active_high  <= 1'b0;
      write_strobe_b      <= 1'b1;
      output_gate_b       <= 1'b1;
      mem_data_oe         <= 1'b0;
      req_ready           <= 1'b0;
    end
    else
    begin
      if (take_req)
      begin
        mem_addr     <= req_addr;
        mem_data_out <= req_wdata;
      end
      select_active_low_b <= !busy;
      select_active_high  <= busy;
      write_strobe_b      <= !pulse_next;
      output_gate_b       <= !in_read;
      mem_data_oe         <= pulse_next;
      req_ready           <= (state_next == sramc_pkg::SRAMC_IDLE) && !take_req;
    end
  end

  // sample read data after the access time has elapsed
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= (state_reg == sramc_pkg::SRAMC_READ) && cnt_done;
      if ((state_reg == sramc_pkg::SRAMC_READ) && cnt_done)
        rsp_rdata <= mem_data_in;
    end
  end

  // strobe low only with both selects active
  a_write_overlap: assert property (@(posedge clk) disable iff (!rst_b)
    !write_strobe_b |-> (!select_active_low_b && select_active_high))
    else $error("write strobe low without both selects");

  // strobe low for at least two cycles (100 ns)
  a_strobe_width: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(write_strobe_b) |-> !write_strobe_b [*2])
    else $error("write pulse too short");

  // active-low select stays active through the strobe rise
  a_select_hold: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(write_strobe_b) && $past(!write_strobe_b) |-> !select_active_low_b)
    else $error("select dropped before write end");

  // address steady while strobe low and one cycle after
  a_addr_stable: assert property (@(posedge clk) disable iff (!rst_b)
    !$past(write_strobe_b) |-> $stable(mem_addr))
    else $error("address moved during write");

  // data driven exactly during the strobe
  a_data_window: assert property (@(posedge clk) disable iff (!rst_b)
    mem_data_oe == !write_strobe_b)
    else $error("data drive not aligned with strobe");

  // no drive while the gate lets the device drive
  a_no_contention: assert property (@(posedge clk) disable iff (!rst_b)
    !output_gate_b |-> !mem_data_oe)
    else $error("pin contention with device");

  // strobe high for whole read
  a_read_strobe: assert property (@(posedge clk) disable iff (!rst_b)
    !output_gate_b |-> write_strobe_b)
    else $error("strobe low during read");

  sequence s_read_start;
    $fell(output_gate_b);
  endsequence
  // response no sooner than access time after read start
  a_read_timing: assert property (@(posedge clk) disable iff (!rst_b)
    s_read_start |-> !rsp_valid [*3] ##[1:3] rsp_valid)
    else $error("read response timing wrong");

  // selects lead the strobe so the device never sees a late select
  a_select_lead: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(write_strobe_b) |-> $past(!select_active_low_b) && $past(select_active_high))
    else $error("strobe fell without selects already active");

  // address already settled when the write begins
  a_addr_setup: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(write_strobe_b) |-> $stable(mem_addr))
    else $error("address moved as write began");

  // address held a cycle past the strobe rise: the write ends on the strobe
  a_addr_recover: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(write_strobe_b) |=> $stable(mem_addr))
    else $error("address changed too soon after write");

  // write byte steady for the whole strobe
  a_data_stable: assert property (@(posedge clk) disable iff (!rst_b)
    !write_strobe_b && $past(!write_strobe_b) |-> $stable(mem_data_out))
    else $error("write data moved during strobe");

  // write steps: two strobe-low cycles, strobe rise, then selects drop
  sequence s_strobe_low;
    !write_strobe_b [*2];
  endsequence
  sequence s_release;
    (write_strobe_b && !select_active_low_b && select_active_high) ##1 select_active_low_b;
  endsequence
  a_write_steps: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(write_strobe_b) |-> s_strobe_low ##1 s_release)
    else $error("write cycle steps out of order");

  // request port reopens right after the write finishes
  a_ready_return: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(write_strobe_b) |=> req_ready)
    else $error("ready did not return after write");

  // idle means pins released and gate closed
  a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    req_ready |-> !mem_data_oe && output_gate_b && write_strobe_b)
    else $error("pins active while idle");

  // gate only opens with both selects active
  a_read_selects: assert property (@(posedge clk) disable iff (!rst_b)
    !output_gate_b |-> !select_active_low_b && select_active_high)
    else $error("gate open without selects");

  // address steady across the whole read
  a_read_addr: assert property (@(posedge clk) disable iff (!rst_b)
    !output_gate_b && $past(!output_gate_b) |-> $stable(mem_addr))
    else $error("address moved during read");

  // gate held open five cycles, past the slowest access time
  a_gate_width: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(output_gate_b) |-> !output_gate_b [*5])
    else $error("gate closed before access time");

  // gate and selects release together, so no other drive overlaps
  a_read_release: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(output_gate_b) |-> select_active_low_b && !select_active_high)
    else $error("selects left active after read");

  // address kept a cycle after the read so old data stays meaningful
  a_read_hold: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(output_gate_b) |-> $stable(mem_addr))
    else $error("address changed as read closed");

  // response is a single-cycle pulse
  a_rsp_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    rsp_valid |=> !rsp_valid)
    else $error("response valid stretched");

  // no write strobe while the response is handed over
  a_rsp_no_write: assert property (@(posedge clk) disable iff (!rst_b)
    rsp_valid |-> write_strobe_b && !mem_data_oe)
    else $error("write activity during read response");
endmodule : sramc_ctrl

/* File: dv/sramc_sram_model.sv */
// behavioural 8k x 8 async sram facing the host controller, with timing watch
`timescale 1ns/1ps
module sramc_sram_model #(
  parameter int RESP_NS = 140
) (
  input  wire logic [sramc_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic                         select_active_low_b,
  input  wire logic                         select_active_high,
  input  wire logic                         write_strobe_b,
  input  wire logic                         output_gate_b,
  input  wire logic [sramc_pkg::DATA_W-1:0] host_data,
  input  wire logic                         host_oe,
  output logic      [sramc_pkg::DATA_W-1:0] dev_data,
  output logic                              dev_drive,
  output int                                viol_count
);
  logic [7:0] mem_arr [0:8191];
  logic [7:0] last_q;
  logic       sel;
  realtime    t_sel, t_addr, t_data, t_wfall, t_wend;
  initial
  begin
    viol_count = 0;
    last_q     = 8'h00;
    t_wend     = -1000.0;
  end
  // deselect floats the pins whatever strobe and gate do
  assign sel       = !select_active_low_b && select_active_high;
  assign dev_drive = sel && write_strobe_b && !output_gate_b;
  // slow answer near the access limit; a released pin shows the inverted last byte
  assign #(RESP_NS) dev_data = dev_drive ? mem_arr[mem_addr] : ~last_q;
  always @(dev_data) if (dev_drive) last_q = dev_data;
  // byte follows the pins for the whole overlap, so the last one written sticks
  always @(sel or write_strobe_b or host_oe or mem_addr or host_data)
    if (sel && !write_strobe_b && host_oe) mem_arr[mem_addr] = host_data;
  always @(posedge sel) t_sel = $realtime;
  always @(posedge host_oe) t_data = $realtime;
  always @(negedge write_strobe_b) t_wfall = $realtime;
  always @(mem_addr)
  begin
    if ($realtime - t_wend < sramc_pkg::WRITE_RECOVERY_NS) viol_count++;
    t_addr = $realtime;
  end
  // the write ends at the strobe rise while both selects stay active
  always @(posedge write_strobe_b)
  begin
    if (sel)
    begin
      t_wend = $realtime;
      if (t_wend - t_wfall < sramc_pkg::WRITE_PULSE_MIN_NS) viol_count++;
      if (t_wend - t_sel < sramc_pkg::SELECT_TO_END_NS) viol_count++;
      if (t_wend - t_addr < sramc_pkg::ADDR_TO_END_NS) viol_count++;
      if (t_wend - t_data < sramc_pkg::DATA_OVERLAP_NS) viol_count++;
    end
  end
endmodule : sramc_sram_model

/* File: dv/tb_top.sv */
// testbench: request traffic through the controller into the sram model
`timescale 1ns/1ps
module tb_top;
  logic                         clk, rst_b, req_valid, req_write, req_ready, rsp_valid;
  logic [sramc_pkg::ADDR_W-1:0] req_addr, mem_addr;
  logic [sramc_pkg::DATA_W-1:0] req_wdata, rsp_rdata, mem_data_out, dev_data, bus, q;
  logic                         sal_b, sah, wr_b, og_b, mem_data_oe, dev_drive;
  int                           num_errors = 0, check_count = 0, viol_count, pin_bad = 0;
  initial clk = 1'h0;
  always #25 clk = ~clk;
  // pins resolve: the controller wins while it drives
  assign bus = mem_data_oe ? mem_data_out : dev_data;
  sramc_ctrl sramc_ctrl_inst (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr),
    .select_active_low_b(sal_b), .select_active_high(sah), .write_strobe_b(wr_b),
    .output_gate_b(og_b), .mem_data_in(bus), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe));
  sramc_sram_model sramc_sram_model_inst (.mem_addr(mem_addr), .select_active_low_b(sal_b),
    .select_active_high(sah), .write_strobe_b(wr_b), .output_gate_b(og_b),
    .host_data(mem_data_out), .host_oe(mem_data_oe), .dev_data(dev_data),
    .dev_drive(dev_drive), .viol_count(viol_count));
  // pin watch on falling edges, where registered pins have settled
  always @(negedge clk)
  begin
    if (rst_b && !wr_b && !(mem_data_oe && !sal_b && sah)) pin_bad++;
    if (rst_b && !og_b && !wr_b) pin_bad++;
    if (dev_drive && mem_data_oe) pin_bad++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin num_errors++; $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp); end
  endtask : check
  // entered at a falling edge; holds the request until taken
  task automatic run_req(input logic wr, input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_valid = 1'h1;
    req_write = wr;
    req_addr  = a;
    req_wdata = d;
    while (req_ready !== 1'h1 && n < 40) begin @(negedge clk); n++; end
    @(negedge clk);
    req_valid = 1'h0;
    check(req_ready, 16'h0);
    n = 0;
    while ((wr ? req_ready : rsp_valid) !== 1'h1 && n < 40) begin @(negedge clk); n++; end
    if (!wr) check(n, 16'h5);
    q = rsp_rdata;
  endtask : run_req
  task automatic t_reset_idle();
    check({sal_b, sah, wr_b, og_b, mem_data_oe, req_ready}, 16'h2C);
    rst_b = 1'h1;
    @(negedge clk);
    check({sal_b, sah, wr_b, og_b, mem_data_oe, req_ready}, 16'h2D);
    $display("reset idle done");
  endtask : t_reset_idle
  task automatic t_corners();
    logic [12:0] a [4];
    logic [7:0]  d [4];
    a = '{13'h0000, 13'h1FFF, 13'h0AAA, 13'h1555};
    d = '{8'h5A, 8'hA5, 8'h00, 8'hFF};
    for (int i = 0; i < 4; i++) run_req(1'h1, a[i], d[i]);
    for (int i = 3; i >= 0; i--) begin run_req(1'h0, a[i], 8'h00); check(q, d[i]); end
    $display("corners done");
  endtask : t_corners
  task automatic t_overwrite();
    run_req(1'h1, 13'h0010, 8'h3C);
    run_req(1'h1, 13'h0010, 8'hC3);
    run_req(1'h1, 13'h0011, 8'h77);
    run_req(1'h0, 13'h0010, 8'h00);
    check(q, 8'hC3);
    run_req(1'h0, 13'h0011, 8'h00);
    check(q, 8'h77);
    check(viol_count, 16'h0);
    check(pin_bad, 16'h0);
    $display("overwrite and pins done");
  endtask : t_overwrite
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial
  begin
    rst_b = 1'h0;
    req_valid = 1'h0;
    req_write = 1'h0;
    req_addr = 13'h0000;
    req_wdata = 8'h00;
    repeat (10) @(negedge clk);
    t_reset_idle();
    t_corners();
    t_overwrite();
    end_of_test();
  end
  // watchdog: the run needs about a hundred cycles
  initial
  begin
    repeat (4000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
endmodule : tb_top
